// >>> common/sfbp_cfg.svh
// constants for the buffered page program flash link and its two ends
// How it works
// - 82H/85H program through buffer one/two
// - host sends four reserved bits as given in cmdAddr[23:20]
// - first 11 address bits pick the page
// - last nine address bits pick buffer start
// - opcode, reserved bits, address shifted after select
// - later bytes fill buffer at rising positions
// - loading past buffer end wraps to start
// - host keeps select low whole sequence
// - select rising starts page erase then program
// - busy on pin and status while running
// - other buffer stays usable during transfer
// - host fills buffer no faster than program time
// - host ping-pongs buffers, waits for ready
// - read opcodes: two per read, per clock mode
// - buffer write, page and block erase decoded
// - buffer program with erase decoded
// - buffer program without erase decoded
// - page to buffer transfer decoded
// - page to buffer compare decoded
// - auto page rewrite decoded
// - clock modes 0 and 3 accepted, data sampled on rising sck
// - buffers hold 264 bytes
`ifndef SFBP_CFG_SVH
`define SFBP_CFG_SVH

`define OP_PROG_THRU_B1 8'h82
`define OP_PROG_THRU_B2 8'h85
`define OP_BUF_WR_B1 8'h84
`define OP_BUF_WR_B2 8'h87
`define OP_BUF_PROG_ER_B1 8'h83
`define OP_BUF_PROG_ER_B2 8'h86
`define OP_BUF_PROG_B1 8'h88
`define OP_BUF_PROG_B2 8'h89
`define OP_PAGE_ERASE 8'h81
`define OP_BLOCK_ERASE 8'h50
`define OP_XFER_B1 8'h53
`define OP_XFER_B2 8'h55
`define OP_CMP_B1 8'h60
`define OP_CMP_B2 8'h61
`define OP_REWRITE_B1 8'h58
`define OP_REWRITE_B2 8'h59
`define OP_ARR_RD_LEG 8'h68
`define OP_ARR_RD_SPI 8'he8
`define OP_PAGE_RD_LEG 8'h52
`define OP_PAGE_RD_SPI 8'hd2
`define OP_B1_RD_LEG 8'h54
`define OP_B1_RD_SPI 8'hd4
`define OP_B2_RD_LEG 8'h56
`define OP_B2_RD_SPI 8'hd6
`define OP_STAT_RD_LEG 8'h57
`define OP_STAT_RD_SPI 8'hd7

`define HDR_BITS 6'd32
`define PAGE_MSB 19
`define PAGE_LSB 9
`define BUF_BYTES 264
`define BUF_LAST 9'h107
`define STAT_READY_BIT 7

`define CLK_PERIOD_NS 20
`define MAX_ERASE_PROGRAM_TIME_NS 20000
`define EP_CYCLES (`MAX_ERASE_PROGRAM_TIME_NS / `CLK_PERIOD_NS)
`define SCK_PHASES 8
`define CS_SETUP_CYCLES 4'h3
`define CS_HOLD_CYCLES 4'h4
`define CS_GAP_CYCLES 4'h8

`endif

// >>> common/sfbp_if.sv
// serial link pins between the host controller and the flash device
`timescale 1ns/10ps
interface sfbp_if;
    logic csN;
    logic sck;
    logic si;
    logic so;
    logic soEn;
    logic ready;
    modport dev(input csN, input sck, input si,
        output so, output soEn, output ready);
    modport host(output csN, output sck, output si,
        input so, input soEn, input ready);
endinterface

// >>> common/sfbp_pkg.sv
// types and opcode classing shared by both ends of the flash link
package sfbp_pkg;
`include "sfbp_cfg.svh"

typedef logic [7:0] opcode_t;
typedef logic [10:0] page_t;

typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_SETUP = 5'h02,
    H_SHIFT = 5'h04,
    H_HOLD = 5'h08,
    H_GAP = 5'h10
} host_state_e;

// self-timed array work started by select rising
function automatic logic progOp(opcode_t o);
    return o inside {`OP_PROG_THRU_B1, `OP_PROG_THRU_B2,
        `OP_BUF_PROG_ER_B1, `OP_BUF_PROG_ER_B2, `OP_BUF_PROG_B1,
        `OP_BUF_PROG_B2, `OP_PAGE_ERASE, `OP_BLOCK_ERASE, `OP_XFER_B1,
        `OP_XFER_B2, `OP_CMP_B1, `OP_CMP_B2, `OP_REWRITE_B1,
        `OP_REWRITE_B2};
endfunction

function automatic logic loadOp(opcode_t o);
    return o inside {`OP_PROG_THRU_B1, `OP_PROG_THRU_B2,
        `OP_BUF_WR_B1, `OP_BUF_WR_B2};
endfunction

function automatic logic bufRdOp(opcode_t o);
    return o inside {`OP_B1_RD_LEG, `OP_B1_RD_SPI, `OP_B2_RD_LEG,
        `OP_B2_RD_SPI};
endfunction

function automatic logic arrRdOp(opcode_t o);
    return o inside {`OP_ARR_RD_LEG, `OP_ARR_RD_SPI, `OP_PAGE_RD_LEG,
        `OP_PAGE_RD_SPI};
endfunction

function automatic logic statOp(opcode_t o);
    return o inside {`OP_STAT_RD_LEG, `OP_STAT_RD_SPI};
endfunction

function automatic logic buf2Op(opcode_t o);
    return o inside {`OP_PROG_THRU_B2, `OP_BUF_WR_B2, `OP_BUF_PROG_ER_B2,
        `OP_BUF_PROG_B2, `OP_XFER_B2, `OP_CMP_B2, `OP_REWRITE_B2,
        `OP_B2_RD_LEG, `OP_B2_RD_SPI};
endfunction

// any opcode that touches one of the two buffers
function automatic logic bufOp(opcode_t o);
    return loadOp(o) || bufRdOp(o) || (progOp(o) &&
        !(o inside {`OP_PAGE_ERASE, `OP_BLOCK_ERASE}));
endfunction

endpackage

// >>> rtl/flash_device.sv
// flash device end: serial command decode, two buffers, busy timing
`timescale 1ns/10ps
module flash_device (
    // serial link
    sfbp_if.dev link,
    // system clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // started array operation
    output logic opStrobe,
    output sfbp_pkg::opcode_t opCode,
    output sfbp_pkg::page_t opPage,
    output logic opBuf2,
    output logic busy
);
    import sfbp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // link domain, clocked by sck, counters cleared by select high
    logic [5:0] hdrCnt_q;
    logic [2:0] bitIdx_q;
    logic [23:0] addr_q;
    opcode_t op_q;
    logic cmdOk_q;
    logic armed_q;
    logic [8:0] ptr_q;
    logic [7:0] txSh_q;
    logic outOn_q;
    logic so_q;
    logic soEn_q;
    logic [7:0] bufMem [0:1][0:`BUF_BYTES-1];
    logic [2:0] bsyS;

    // clock domain state
    logic csS;
    logic csPrev_q;
    logic busy_q;
    logic [1:0] busyBuf_q;
    logic [15:0] tmr_q;
    logic rdy_q;
    logic strobe_q;
    opcode_t opCode_q;
    page_t opPage_q;
    logic opBuf2_q;

    // first byte position, folded back into the buffer
    function automatic logic [8:0] wrapPtr(logic [8:0] p);
        return (p > `BUF_LAST) ? 9'(p - 9'(`BUF_BYTES)) : p;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // busy state brought into the link domain; only read once a frame
    // has run eight edges, so the sync has settled by then
    sync2 #(.W(3), .RST(3'h0)) u_bsySync (
        .clk(link.sck),
        .rst_n(1'b1),
        .d({busy_q, busyBuf_q}),
        .q(bsyS)
    );

    // header and byte decode
    wire [7:0] opNow = {addr_q[6:0], link.si};
    wire [8:0] startNow = {addr_q[7:0], link.si};
    wire inHdr = hdrCnt_q < `HDR_BITS;
    wire opEnd = hdrCnt_q == 6'd7;
    wire addrEnd = hdrCnt_q == 6'd31;
    wire dataEnd = !inHdr && (hdrCnt_q >= 6'd39) && (bitIdx_q == 3'h7);
    wire byteEnd = inHdr ? (hdrCnt_q[2:0] == 3'h7) : (bitIdx_q == 3'h7);
    wire [7:0] rxByte = {addr_q[6:0], link.si};
    wire curBuf = buf2Op(op_q);
    wire [8:0] ptrNext = (ptr_q == `BUF_LAST) ? 9'h000 : 9'(ptr_q + 9'h1);
    wire [7:0] statByte = {~bsyS[2], 7'h00};
    wire blocked = bsyS[2] && (progOp(opNow) || arrRdOp(opNow) ||
        (bufOp(opNow) && bsyS[buf2Op(opNow)]));
    wire wantOut = cmdOk_q && ((statOp(op_q) && byteEnd &&
        hdrCnt_q >= 6'd7) || ((bufRdOp(op_q) || arrRdOp(op_q)) &&
        dataEnd));
    wire [7:0] txNext = statOp(op_q) ? statByte :
        bufRdOp(op_q) ? bufMem[curBuf][ptr_q] : 8'hff;

    // bit counters, restarted by every falling select
    always_ff @(posedge link.sck or posedge link.csN) begin
        if (link.csN) begin
            hdrCnt_q <= 6'h00;
            bitIdx_q <= 3'h0;
        end else begin
            if (hdrCnt_q != 6'd40) hdrCnt_q <= 6'(hdrCnt_q + 6'h1);
            if (!inHdr) bitIdx_q <= 3'(bitIdx_q + 3'h1);
        end
    end

    // header shift, msb first; the last 24 bits form the address, whose low byte then shifts in data
    always_ff @(posedge link.sck) begin
        if (inHdr) addr_q <= {addr_q[22:0], link.si};
        if (!inHdr) addr_q[7:0] <= rxByte;
        if (opEnd) op_q <= opNow;
    end

    // acceptance, taken at the last opcode bit
    always_ff @(posedge link.sck or posedge link.csN) begin
        if (link.csN) cmdOk_q <= 1'b0;
        else if (opEnd) cmdOk_q <= !blocked;
    end

    // arm the self-timed work once the full address is in
    always_ff @(posedge link.sck) begin
        if (hdrCnt_q == 6'h00) armed_q <= 1'b0;
        else if (addrEnd) armed_q <= cmdOk_q && progOp(op_q);
    end

    // buffer pointer and buffer loading
    always_ff @(posedge link.sck) begin
        if (addrEnd) begin
            ptr_q <= wrapPtr(startNow);
        end else if (dataEnd && cmdOk_q && (loadOp(op_q) ||
            bufRdOp(op_q))) begin
            ptr_q <= ptrNext;
        end
        if (dataEnd && cmdOk_q && loadOp(op_q)) begin
            bufMem[curBuf][ptr_q] <= rxByte;
        end
    end

    // transmit shifter; load on a byte edge, shift otherwise
    always_ff @(posedge link.sck or posedge link.csN) begin
        if (link.csN) begin
            txSh_q <= 8'h00;
            outOn_q <= 1'b0;
        end else if (wantOut) begin
            txSh_q <= txNext;
            outOn_q <= 1'b1;
        end else begin
            txSh_q <= {txSh_q[6:0], 1'b0};
        end
    end

    // output pin changes on the falling edge so the host samples rising
    always_ff @(negedge link.sck or posedge link.csN) begin
        if (link.csN) begin
            so_q <= 1'b0;
            soEn_q <= 1'b0;
        end else begin
            so_q <= txSh_q[7];
            soEn_q <= outOn_q;
        end
    end

    assign link.so = so_q;
    assign link.soEn = soEn_q;
    assign link.ready = rdy_q;

    ////////////////////////////////////////////////////////////////////
    // clock domain: select is a pin, synchronised before use
    sync2 #(.W(1), .RST(1'b1)) u_csSync (
        .clk(clk),
        .rst_n(rst_n),
        .d(link.csN),
        .q(csS)
    );

    // sck stands still once select is high, so the link registers are
    // quiet by the time the synchronised rising edge is seen
    wire csRise = csS && !csPrev_q;
    wire start = csRise && armed_q && !busy_q;
    wire finish = busy_q && (tmr_q == 16'h0000);

    // self-timed erase and program sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            csPrev_q <= 1'b1;
            busy_q <= 1'b0;
            busyBuf_q <= 2'b00;
            tmr_q <= 16'h0000;
            rdy_q <= 1'b1;
            strobe_q <= 1'b0;
            opCode_q <= 8'h00;
            opPage_q <= 11'h000;
            opBuf2_q <= 1'b0;
        end else begin
            csPrev_q <= csS;
            strobe_q <= start;
            if (start) begin
                busy_q <= 1'b1;
                rdy_q <= 1'b0;
                tmr_q <= 16'(`EP_CYCLES - 1);
                opCode_q <= op_q;
                opPage_q <= addr_q[`PAGE_MSB:`PAGE_LSB];
                opBuf2_q <= buf2Op(op_q);
                busyBuf_q <= !bufOp(op_q) ? 2'b00 :
                    (buf2Op(op_q) ? 2'b10 : 2'b01);
            end else if (finish) begin
                busy_q <= 1'b0;
                rdy_q <= 1'b1;
                busyBuf_q <= 2'b00;
            end else if (busy_q) begin
                tmr_q <= 16'(tmr_q - 16'h1);
            end
        end
    end

    assign opStrobe = strobe_q;
    assign opCode = opCode_q;
    assign opPage = opPage_q;
    assign opBuf2 = opBuf2_q;
    assign busy = busy_q;
endmodule

// >>> rtl/flash_host.sv
// host controller end: frames commands and data onto the serial link
`timescale 1ns/10ps
module flash_host (
    // serial link
    sfbp_if.host link,
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command request
    input wire logic cmdValid,
    input wire sfbp_pkg::opcode_t cmdOpcode,
    input wire logic [23:0] cmdAddr,
    input wire logic [9:0] cmdLen,
    input wire logic cmdRead,
    input wire logic idleHigh,
    output logic cmdReady,
    // write bytes
    input wire logic wrValid,
    input wire logic [7:0] wrData,
    output logic wrTaken,
    // read bytes and status
    output logic rdValid,
    output logic [7:0] rdData,
    output logic done,
    output logic devReady
);
    import sfbp_pkg::*;

    host_state_e state_q;
    logic [2:0] phase_q;
    logic [13:0] bitCnt_q;
    logic [13:0] total_q;
    logic [31:0] tx_q;
    logic [7:0] rx_q;
    logic rd_q, idle_q, have_q;
    logic csN_q, sck_q, si_q;
    logic [3:0] wait_q;
    logic ready_q, taken_q, rdValid_q, done_q;
    logic [7:0] rdData_q;
    logic soS, rdyS;

    ////////////////////////////////////////////////////////////////////
    // device pins come from the link domain
    sync2 #(.W(2), .RST(2'b01)) u_pinSync (
        .clk(clk),
        .rst_n(rst_n),
        .d({link.so, link.ready}),
        .q({soS, rdyS})
    );

    // byte boundaries and stalling for write data
    wire pastHdr = bitCnt_q >= 14'd32;
    wire lastDone = bitCnt_q == total_q;
    wire needByte = pastHdr && (bitCnt_q[2:0] == 3'h0) && !rd_q &&
        !lastDone;
    wire stall = (phase_q == 3'h0) && needByte && !have_q;
    wire rdByte = rd_q && pastHdr && (bitCnt_q[2:0] == 3'h7);

    ////////////////////////////////////////////////////////////////////
    // frame sequencer; sck is clk divided by eight
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= H_IDLE;
            phase_q <= 3'h0;
            bitCnt_q <= 14'h0000;
            total_q <= 14'h0000;
            tx_q <= 32'h00000000;
            rx_q <= 8'h00;
            rd_q <= 1'b0;
            idle_q <= 1'b0;
            have_q <= 1'b0;
            csN_q <= 1'b1;
            sck_q <= 1'b0;
            si_q <= 1'b0;
            wait_q <= 4'h0;
            ready_q <= 1'b1;
            taken_q <= 1'b0;
            rdValid_q <= 1'b0;
            rdData_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            taken_q <= 1'b0;
            rdValid_q <= 1'b0;
            done_q <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    if (cmdValid) begin
                        // reserved bits are whatever the caller puts in
                        // cmdAddr[23:20]; zero keeps them compatible
                        tx_q <= {cmdOpcode, cmdAddr};
                        total_q <= 14'({cmdLen, 3'h0} + 14'd32);
                        rd_q <= cmdRead;
                        idle_q <= idleHigh;
                        sck_q <= idleHigh;
                        bitCnt_q <= 14'h0000;
                        phase_q <= 3'h0;
                        have_q <= 1'b0;
                        csN_q <= 1'b0;
                        wait_q <= `CS_SETUP_CYCLES;
                        ready_q <= 1'b0;
                        state_q <= H_SETUP;
                    end else begin
                        sck_q <= idleHigh;
                    end
                end
                H_SETUP: begin
                    if (wait_q == 4'h0) state_q <= H_SHIFT;
                    else wait_q <= 4'(wait_q - 4'h1);
                end
                H_SHIFT: begin
                    if (phase_q == 3'h0 && lastDone) begin
                        sck_q <= idle_q;
                        wait_q <= `CS_HOLD_CYCLES;
                        state_q <= H_HOLD;
                    end else if (stall) begin
                        if (wrValid) begin
                            tx_q[31:24] <= wrData;
                            have_q <= 1'b1;
                            taken_q <= 1'b1;
                        end
                    end else begin
                        phase_q <= 3'(phase_q + 3'h1);
                        if (phase_q == 3'h0) begin
                            sck_q <= 1'b0;
                            si_q <= tx_q[31];
                        end
                        if (phase_q == 3'h4) begin
                            sck_q <= 1'b1;
                            rx_q <= {rx_q[6:0], soS};
                        end
                        if (phase_q == 3'h7) begin
                            tx_q <= {tx_q[30:0], 1'b0};
                            bitCnt_q <= 14'(bitCnt_q + 14'h1);
                            have_q <= 1'b0;
                            if (rdByte) begin
                                rdData_q <= rx_q;
                                rdValid_q <= 1'b1;
                            end
                        end
                    end
                end
                H_HOLD: begin
                    if (wait_q == 4'h0) begin
                        csN_q <= 1'b1;
                        wait_q <= `CS_GAP_CYCLES;
                        state_q <= H_GAP;
                    end else begin
                        wait_q <= 4'(wait_q - 4'h1);
                    end
                end
                H_GAP: begin
                    if (wait_q == 4'h0) begin
                        done_q <= 1'b1;
                        ready_q <= 1'b1;
                        state_q <= H_IDLE;
                    end else begin
                        wait_q <= 4'(wait_q - 4'h1);
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    // ready pin level for the caller's ping-pong loop
    always_ff @(posedge clk) begin
        if (!rst_n) devReady <= 1'b0;
        else devReady <= rdyS;
    end

    assign link.csN = csN_q;
    assign link.sck = sck_q;
    assign link.si = si_q;
    assign cmdReady = ready_q;
    assign wrTaken = taken_q;
    assign rdValid = rdValid_q;
    assign rdData = rdData_q;
    assign done = done_q;
endmodule

// >>> rtl/sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset of the receiving domain
    input wire logic clk,
    input wire logic rst_n,
    // level in, level out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= RST;
            q <= RST;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// >>> sim/serial_flash_buffered_page_program_tb.sv
// self-checking bench: host and device ends joined by the serial link
`timescale 1ns/10ps
module serial_flash_buffered_page_program_tb;
    import sfbp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmdValid = 1'b0, cmdRead = 1'b0, idleHigh = 1'b0, wrValid = 1'b0;
    opcode_t cmdOpcode = 8'h00;
    logic [23:0] cmdAddr = 24'h000000;
    logic [9:0] cmdLen = 10'h000;
    logic [7:0] wrData = 8'h00;
    logic cmdReady, wrTaken, rdValid, done, devReady;
    logic opStrobe, opBuf2, busy;
    logic [7:0] rdData;
    opcode_t opCode;
    page_t opPage;
    logic [7:0] mem [2][264];
    logic [7:0] wrQ [$];
    logic [7:0] rdQ [$];
    int nErrors = 0, numChecks = 0, nStarts = 0, starts = 0;
    integer seed = 32'h153874d2;
    page_t pg;
    opcode_t pOps [12] = '{8'h81, 8'h50, 8'h83, 8'h86, 8'h88, 8'h89,
        8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59};
    opcode_t rOps [6] = '{8'h68, 8'he8, 8'h52, 8'hd2, 8'h57, 8'hd7};

    ////////////////////////////////////////////////////////////////////////
    // the two ends face each other; the checker watches the pins
    sfbp_if link();
    flash_device flash_device_inst (.link(link.dev), .clk(clk),
        .rst_n(rst_n), .opStrobe(opStrobe), .opCode(opCode),
        .opPage(opPage), .opBuf2(opBuf2), .busy(busy));
    flash_host flash_host_inst (.link(link.host), .clk(clk), .rst_n(rst_n),
        .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr),
        .cmdLen(cmdLen), .cmdRead(cmdRead), .idleHigh(idleHigh),
        .cmdReady(cmdReady), .wrValid(wrValid), .wrData(wrData),
        .wrTaken(wrTaken), .rdValid(rdValid), .rdData(rdData),
        .done(done), .devReady(devReady));
    sfbp_properties sfbp_properties_inst (.clk(clk), .rst_n(rst_n),
        .csN(link.csN), .sck(link.sck), .si(link.si), .so(link.so),
        .soEn(link.soEn), .ready(link.ready));

    // 50 MHz system clock; the link clock is divided down by the host
    always #10 clk = ~clk;

    // count started array operations as they pulse
    always @(posedge clk) begin
        if (opStrobe === 1'b1) nStarts <= nStarts + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [23:0] got, exp);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (nErrors == 0 && numChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // queue bytes for the host and mirror them into the buffer model
    task automatic fill(input int b, input int st, input int n);
        logic [7:0] d;
        for (int k = 0; k < n; k++) begin
            d = 8'($random(seed));
            wrQ.push_back(d);
            mem[b][(st + k) % 264] = d;
        end
    endtask

    // one whole frame; bytes are handed over only on wrTaken
    task automatic xfer(input opcode_t op, input logic [23:0] addr,
            input int len, input logic rd, input logic mode);
        int guard;
        guard = 0;
        while (cmdReady !== 1'b1) @(negedge clk);
        // clock moves to its new idle level a cycle before select falls,
        // so the device never sees both pins change in one time step
        idleHigh = mode;
        @(negedge clk);
        cmdOpcode = op;
        cmdAddr = addr;
        cmdLen = len[9:0];
        cmdRead = rd;
        wrValid = wrQ.size() > 0;
        if (wrValid) wrData = wrQ[0];
        cmdValid = 1'b1;
        rdQ.delete();
        @(negedge clk);
        cmdValid = 1'b0;
        while (done !== 1'b1 && guard < 40000) begin
            @(negedge clk);
            guard++;
            if (wrTaken === 1'b1) begin
                void'(wrQ.pop_front());
                wrValid = wrQ.size() > 0;
                if (wrValid) wrData = wrQ[0];
            end
            if (rdValid === 1'b1) rdQ.push_back(rdData);
        end
        chk("frame done", done, 1'b1);
        chk("read byte count", rdQ.size(), rd ? len : 0);
    endtask

    task automatic expStart(input opcode_t op, input page_t p, input logic b2);
        starts++;
        chk("op count", nStarts, starts);
        chk("opCode", opCode, op);
        chk("opPage", opPage, p);
        chk("opBuf2", opBuf2, b2);
        chk("busy", busy, 1'b1);
        chk("ready pin", link.ready, 1'b0);
    endtask

    task automatic waitReady();
        int guard;
        guard = 0;
        while (devReady !== 1'b1 && guard < 3000) begin
            @(negedge clk);
            guard++;
        end
        chk("busy after op", busy, 1'b0);
    endtask

    // buffer read: one dummy byte, then data compared with the model
    task automatic rdBuf(input opcode_t op, input int b, input int st,
            input int n, input logic mode);
        xfer(op, {15'h0000, st[8:0]}, n + 1, 1'b1, mode);
        for (int k = 0; k < n; k++) begin
            chk("buffer byte", rdQ[k + 1], mem[b][(st + k) % 264]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // bound well above the expected run of about 30000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        nErrors++;
        wrap_up();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        pg = $random(seed);
        fill(0, 260, 8);
        xfer(8'h82, {4'h0, pg, 9'd260}, 8, 1'b0, 1'b0);
        expStart(8'h82, pg, 1'b0);
        xfer(8'h57, 24'h000000, 1, 1'b1, 1'b0);
        chk("status busy", rdQ[0], 8'h00);
        xfer(8'h83, {4'h0, pg, 9'h000}, 0, 1'b0, 1'b1);
        chk("refused op", nStarts, starts);
        fill(1, 5, 6);
        xfer(8'h87, {15'h0000, 9'd5}, 6, 1'b0, 1'b1);
        rdBuf(8'hd6, 1, 5, 6, 1'b1);
        waitReady();
        pg = $random(seed);
        xfer(8'h86, {4'h0, pg, 9'h000}, 0, 1'b0, 1'b1);
        expStart(8'h86, pg, 1'b1);
        waitReady();
        rdBuf(8'h54, 0, 260, 4, 1'b0);
        rdBuf(8'hd4, 0, 0, 4, 1'b1);
        // program through buffer two, buffer one written while it runs
        pg = 11'($random(seed));
        fill(1, 100, 3);
        xfer(8'h85, {4'h0, pg, 9'd100}, 3, 1'b0, 1'b0);
        expStart(8'h85, pg, 1'b1);
        fill(0, 10, 2);
        xfer(8'h84, {15'h0000, 9'd10}, 2, 1'b0, 1'b1);
        waitReady();
        rdBuf(8'h56, 1, 100, 3, 1'b0);
        rdBuf(8'h54, 0, 10, 2, 1'b1);
        // every self-timed opcode but 82H/85H, alternating the clock idle level
        for (int i = 0; i < 12; i++) begin
            pg = $random(seed);
            xfer(pOps[i], {4'h0, pg, 9'h000}, 0, 1'b0, i[0]);
            expStart(pOps[i], pg, (i >= 2) && i[0]);
            waitReady();
        end
        // array reads give erased data, status reads give ready
        for (int i = 0; i < 6; i++) begin
            xfer(rOps[i], 24'h000000, 6, 1'b1, i[0]);
            chk("read last byte", rdQ[5], (i < 4) ? 8'hff : 8'h80);
        end
        wrap_up();
    end
endmodule

// >>> sim/sfbp_properties.sv
// timing checks on the serial flash link pins
`timescale 1ns/10ps
`include "sfbp_cfg.svh"
module sfbp_properties (
    // system clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link pins
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic soEn,
    input wire logic ready
);
    localparam int EP = `EP_CYCLES;
    int lowCnt_q;
    int hiCnt_q;
    int selCnt_q;

    ////////////////////////////////////////////////////////////////////////
    // run lengths of busy, deselect and select, saturating where unbounded
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowCnt_q <= 0;
            hiCnt_q <= 0;
            selCnt_q <= 0;
        end else begin
            lowCnt_q <= ready ? 0 : lowCnt_q + 1;
            hiCnt_q <= csN ? ((hiCnt_q < 255) ? hiCnt_q + 1 : hiCnt_q) : 0;
            selCnt_q <= csN ? 0 : selCnt_q + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_header_length: assert property ($rose(csN) |-> selCnt_q >= 256)
        else $error("select released before a full header");
    a_setup_idle: assert property ($fell(csN) |=> $stable(sck)[*3])
        else $error("clock left idle level during select setup");
    a_sck_high_wide: assert property (!csN && $rose(sck) |-> sck[*4])
        else $error("clock high phase too short");
    a_sck_low_wide: assert property (!csN && $fell(sck) |-> !sck[*4])
        else $error("clock low phase too short");
    a_si_held_high: assert property (
        !csN && $rose(sck) |=> $stable(si)[*3])
        else $error("data in moved while clock high");
    a_cs_gap: assert property ($rose(csN) |=> csN[*4])
        else $error("deselect gap too short");
    a_so_released: assert property (csN |-> !soEn)
        else $error("data out driven while deselected");
    a_busy_start: assert property (
        $fell(ready) |-> csN && hiCnt_q inside {[2:6]})
        else $error("busy not started by select rising");
    a_busy_length: assert property (
        $rose(ready) |-> lowCnt_q inside {[EP-2:EP+2]})
        else $error("busy length wrong");
    a_busy_bound: assert property (!ready |-> lowCnt_q <= EP + 2)
        else $error("busy runs too long");

    // main scenarios reached
    c_busy: cover property ($fell(ready));
    c_read_out: cover property ($rose(soEn));
    c_mode_high: cover property ($fell(csN) && sck);
endmodule
